// *** hdl/eoc_pkg.sv ***
// Constants and types for the external oscillator control block.
// Assumes an SFR bus with page select, address, write and read strobes.
package eoc_pkg;

   // ==========================================================
   // Register location
   localparam logic [7:0] EXT_OSC_CONTROL_ADDR = 8'h9F;
   localparam logic [7:0] EXT_OSC_CONTROL_PAGE = 8'h0F;
   localparam logic [7:0] EXT_OSC_CONTROL_RST  = 8'h00;

   // ==========================================================
   // Field positions
   localparam int VALID_BIT  = 7;
   localparam int MODE_HI    = 6;
   localparam int MODE_LO    = 4;
   localparam int FREQ_HI    = 2;
   localparam int FREQ_LO    = 0;

   // ==========================================================
   // Mode encodings
   localparam logic [2:0] MODE_OFF0     = 3'h0;
   localparam logic [2:0] MODE_OFF1     = 3'h1;
   localparam logic [2:0] MODE_CMOS     = 3'h2;
   localparam logic [2:0] MODE_CMOS_DIV = 3'h3;
   localparam logic [2:0] MODE_RC       = 3'h4;
   localparam logic [2:0] MODE_CAP      = 3'h5;
   localparam logic [2:0] MODE_XTAL     = 3'h6;
   localparam logic [2:0] MODE_XTAL_DIV = 3'h7;
   localparam logic [2:0] FREQ_LOWEST   = 3'h0;

   // Decoded oscillator kind
   typedef enum logic [2:0]
   {
      EOC_OFF,
      EOC_CMOS,
      EOC_RC,
      EOC_CAP,
      EOC_XTAL
   } eoc_kind_t;

   // Controls handed to the analog drive circuit
   typedef struct packed
   {
      logic       osc_enable;
      eoc_kind_t  kind;
      logic       div2;
      logic       use_pin_in;
      logic       use_pin_out;
      logic [2:0] freq;
   } eoc_drive_t;

endpackage

// *** hdl/eoc_ext_osc_control.sv ***
// External oscillator control register and drive-circuit decode.
// Assumes an SFR bus synchronous to sys_clk_i; analog status inputs are
// already synchronous to sys_clk_i.
module eoc_ext_osc_control
(
   // Clock and reset
   input  wire logic               sys_clk_i,
   input  wire logic               sys_rst_i,
   // SFR bus
   input  wire logic [7:0]         sfr_page_i,
   input  wire logic [7:0]         sfr_addr_i,
   input  wire logic               sfr_wr_i,
   input  wire logic               sfr_rd_i,
   input  wire logic [7:0]         sfr_wdata_i,
   output logic      [7:0]         sfr_rdata_o,
   output logic                    sfr_hit_o,
   // Analog amplitude detector
   input  wire logic               amp_stable_i,
   // Drive circuit controls
   output eoc_pkg::eoc_drive_t     drive_o
);

   // ==========================================================
   // Address decode
   // Register fields and the page and address match
   logic       sel;
   logic [2:0] ext_osc_mode_select;
   logic [2:0] ext_osc_freq_control;
   logic       crystal_valid_flag;

   // Register selected on the right page and address
   function automatic logic hit(input logic [7:0] page, input logic [7:0] addr);
      return (page == eoc_pkg::EXT_OSC_CONTROL_PAGE) &&
             (addr == eoc_pkg::EXT_OSC_CONTROL_ADDR);
   endfunction

   // True for crystal encodings 11x
   function automatic logic is_xtal(input logic [2:0] m);
      return (m == eoc_pkg::MODE_XTAL) || (m == eoc_pkg::MODE_XTAL_DIV);
   endfunction

   // Hit flags an access to this register in the current cycle
   assign sel       = hit(sfr_page_i, sfr_addr_i);
   assign sfr_hit_o = sel & (sfr_wr_i | sfr_rd_i);

   // ==========================================================
   // Writable fields
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         // Clear leaves the oscillator off
         ext_osc_mode_select  <= eoc_pkg::EXT_OSC_CONTROL_RST[eoc_pkg::MODE_HI:eoc_pkg::MODE_LO];
         ext_osc_freq_control <= eoc_pkg::EXT_OSC_CONTROL_RST[eoc_pkg::FREQ_HI:eoc_pkg::FREQ_LO];
      end
      else if (sel && sfr_wr_i)
      begin
         // Bits 7 and 3 of the write are dropped
         ext_osc_mode_select  <= sfr_wdata_i[eoc_pkg::MODE_HI:eoc_pkg::MODE_LO];
         ext_osc_freq_control <= sfr_wdata_i[eoc_pkg::FREQ_HI:eoc_pkg::FREQ_LO];
      end
   end

   // ==========================================================
   // Crystal valid flag, only reported in crystal modes
   // Gating by mode stops a stale amplitude reading as valid
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         crystal_valid_flag <= 1'b0;
      else
         crystal_valid_flag <= amp_stable_i & is_xtal(ext_osc_mode_select);
   end

   // ==========================================================
   // Read data, registered; bit 3 reads zero
   // Zero between reads so a stray sample sees nothing
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         sfr_rdata_o <= eoc_pkg::EXT_OSC_CONTROL_RST;
      else if (sel && sfr_rd_i)
         sfr_rdata_o <= {crystal_valid_flag, ext_osc_mode_select, 1'b0,
                         ext_osc_freq_control};
      else
         sfr_rdata_o <= eoc_pkg::EXT_OSC_CONTROL_RST;
   end

   // ==========================================================
   // Mode decode to drive-circuit controls
   eoc_pkg::eoc_drive_t next_drive;

   always_comb
   begin
      next_drive      = '0;
      next_drive.freq = ext_osc_freq_control;
      case (ext_osc_mode_select)
         eoc_pkg::MODE_OFF0,
         eoc_pkg::MODE_OFF1:     next_drive.kind = eoc_pkg::EOC_OFF;
         eoc_pkg::MODE_CMOS:     next_drive.kind = eoc_pkg::EOC_CMOS;
         eoc_pkg::MODE_CMOS_DIV:
         begin
            next_drive.kind = eoc_pkg::EOC_CMOS;
            next_drive.div2 = 1'b1;
         end
         eoc_pkg::MODE_RC:       next_drive.kind = eoc_pkg::EOC_RC;
         eoc_pkg::MODE_CAP:      next_drive.kind = eoc_pkg::EOC_CAP;
         eoc_pkg::MODE_XTAL:     next_drive.kind = eoc_pkg::EOC_XTAL;
         default:
         begin
            next_drive.kind = eoc_pkg::EOC_XTAL;
            next_drive.div2 = 1'b1;
         end
      endcase
      next_drive.osc_enable  = (next_drive.kind != eoc_pkg::EOC_OFF);
      next_drive.use_pin_out = next_drive.osc_enable;
      next_drive.use_pin_in  = (next_drive.kind == eoc_pkg::EOC_XTAL);
   end

   // Drive controls from flip-flops
   // Registered so the analog side never sees decode glitches
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         drive_o <= '0;
      else
         drive_o <= next_drive;
   end

   // ==========================================================
   // Checks
   // All checks sample on the rising clock edge and rest during reset
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   // Writes land in both fields; other cycles leave them alone
   chk_write_fields: assert property (sel && sfr_wr_i |=>
      ext_osc_mode_select == $past(sfr_wdata_i[eoc_pkg::MODE_HI:eoc_pkg::MODE_LO]) &&
      ext_osc_freq_control == $past(sfr_wdata_i[eoc_pkg::FREQ_HI:eoc_pkg::FREQ_LO]))
      else $error("write fields not stored");
   chk_no_stray_write: assert property (!(sel && sfr_wr_i) |=>
      $stable(ext_osc_freq_control)) else $error("range changed without write");
   chk_no_stray_mode: assert property (!(sel && sfr_wr_i) |=>
      $stable(ext_osc_mode_select)) else $error("mode changed without write");

   // Strobes off the register's page or address never hit
   chk_page_decode: assert property (sfr_page_i != eoc_pkg::EXT_OSC_CONTROL_PAGE |->
      !sfr_hit_o) else $error("hit on another page");
   chk_addr_decode: assert property (sfr_addr_i != eoc_pkg::EXT_OSC_CONTROL_ADDR |->
      !sfr_hit_o) else $error("hit on another address");

   // Read data stands one cycle after the read, zero otherwise
   chk_read_bit3: assert property (sfr_rdata_o[3] == 1'b0)
      else $error("bit 3 read nonzero");
   chk_read_data: assert property (sel && sfr_rd_i |=>
      sfr_rdata_o == {$past(crystal_valid_flag), $past(ext_osc_mode_select), 1'b0,
                      $past(ext_osc_freq_control)}) else $error("read data wrong");
   chk_idle_rdata: assert property (!(sel && sfr_rd_i) |=>
      sfr_rdata_o == eoc_pkg::EXT_OSC_CONTROL_RST) else $error("read data without read");

   // Valid flag follows the amplitude detector, gated by mode
   chk_valid_mode: assert property (!is_xtal(ext_osc_mode_select) |=> !crystal_valid_flag)
      else $error("valid flag outside crystal mode");
   chk_valid_follow: assert property (is_xtal(ext_osc_mode_select) && amp_stable_i
      |=> crystal_valid_flag) else $error("valid flag missed");
   chk_valid_drop: assert property (!amp_stable_i |=> !crystal_valid_flag)
      else $error("valid flag without stable amplitude");

   // Off modes keep the drive circuit idle
   chk_off_mode: assert property ((ext_osc_mode_select == eoc_pkg::MODE_OFF0 ||
      ext_osc_mode_select == eoc_pkg::MODE_OFF1) |=>
      !drive_o.osc_enable && !drive_o.use_pin_out) else $error("off mode drives");

   // Oscillator kind follows the mode select
   chk_kind_cmos: assert property ((ext_osc_mode_select == eoc_pkg::MODE_CMOS ||
      ext_osc_mode_select == eoc_pkg::MODE_CMOS_DIV) |=>
      drive_o.kind == eoc_pkg::EOC_CMOS) else $error("cmos kind wrong");
   chk_kind_rc: assert property (ext_osc_mode_select == eoc_pkg::MODE_RC |=>
      drive_o.kind == eoc_pkg::EOC_RC) else $error("rc kind wrong");
   chk_kind_cap: assert property (ext_osc_mode_select == eoc_pkg::MODE_CAP |=>
      drive_o.kind == eoc_pkg::EOC_CAP) else $error("capacitor kind wrong");
   chk_kind_xtal: assert property (is_xtal(ext_osc_mode_select) |=>
      drive_o.kind == eoc_pkg::EOC_XTAL) else $error("crystal kind wrong");

   // Pin use, divide stage and range reach the drive circuit
   chk_pins_xtal: assert property (##1 drive_o.use_pin_in ==
      is_xtal($past(ext_osc_mode_select))) else $error("pin use wrong");
   chk_pin_out: assert property (##1 drive_o.use_pin_out ==
      ($past(ext_osc_mode_select) != eoc_pkg::MODE_OFF0 &&
       $past(ext_osc_mode_select) != eoc_pkg::MODE_OFF1)) else $error("output pin use wrong");
   chk_div_stage: assert property (##1 drive_o.div2 ==
      ($past(ext_osc_mode_select) == eoc_pkg::MODE_CMOS_DIV ||
       $past(ext_osc_mode_select) == eoc_pkg::MODE_XTAL_DIV)) else $error("divide wrong");
   chk_freq_pass: assert property (##1 drive_o.freq == $past(ext_osc_freq_control))
      else $error("range not passed");

   // Main scenarios
   cov_xtal_valid: cover property (is_xtal(ext_osc_mode_select) ##1 crystal_valid_flag);
   cov_lower_range: cover property (crystal_valid_flag && sel && sfr_wr_i &&
      sfr_wdata_i[eoc_pkg::FREQ_HI:eoc_pkg::FREQ_LO] == eoc_pkg::FREQ_LOWEST);
   cov_cap_mode: cover property (ext_osc_mode_select == eoc_pkg::MODE_CAP);
   cov_cmos_div: cover property (drive_o.kind == eoc_pkg::EOC_CMOS && drive_o.div2);
   cov_valid_read: cover property (crystal_valid_flag && sel && sfr_rd_i);

endmodule

// *** testbench/eoc_crystal_model.sv ***
// Behavioural crystal: amplitude settles a while after it is driven.
// Assumes the drive controls of the oscillator control block.
module eoc_crystal_model
#(
   parameter int SETTLE = 400
)
(
   // Clock, reset and drive
   input  wire logic                sys_clk_i,
   input  wire logic                sys_rst_i,
   input  wire eoc_pkg::eoc_drive_t drive_i,
   // Amplitude detector
   output logic                     amp_stable_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // Settling count restarts whenever the crystal drive stops
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         cnt <= 0;
      else if (!(drive_i.osc_enable && drive_i.kind == eoc_pkg::EOC_XTAL))
         cnt <= 0;
      else if (cnt < SETTLE)
         cnt <= cnt + 1;
   end
   assign amp_stable_o = (cnt == SETTLE);
endmodule

// *** testbench/external_oscillator_control_test.sv ***
// Self-checking bench for the external oscillator control register.
// Assumes the crystal model on the amplitude detector input.
module external_oscillator_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                sys_clk_i = 0, sys_rst_i = 1, wr = 0, rd = 0, amp, hit;
   logic [7:0]          page = 0, addr = 0, wdata = 0, rdata, v, d;
   eoc_pkg::eoc_drive_t drv, ex;
   int                  err_total = 0, compares = 0;
   eoc_ext_osc_control uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sfr_page_i(page),
      .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
      .sfr_rdata_o(rdata), .sfr_hit_o(hit), .amp_stable_i(amp), .drive_o(drv));
   eoc_crystal_model #(.SETTLE(400)) xtal (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .drive_i(drv), .amp_stable_o(amp));
   // 250 MHz clock
   initial forever #2 sys_clk_i = ~sys_clk_i;
   task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s exp %h seen %h", n, exp, seen);
      end
   endtask
   // One register access; read data kept in v
   task automatic acc(logic w, logic [7:0] p, logic [7:0] a, logic [7:0] dat);
      @(negedge sys_clk_i);
      {wr, rd, page, addr, wdata} = {w, !w, p, a, dat};
      #1 chk("hit", hit, 8'(p == 8'h0F && a == 8'h9F));
      @(negedge sys_clk_i);
      {wr, rd} = 2'b00;
      v = rdata;
   endtask
   // Expected drive controls for a mode and range
   function automatic eoc_pkg::eoc_drive_t exp_drv(logic [2:0] m, logic [2:0] f);
      exp_drv = '0;
      if (m[2:1] != 2'b00)
      begin
         exp_drv.osc_enable = 1'b1;
         exp_drv.kind = m[2:1] == 2'b01 ? eoc_pkg::EOC_CMOS : m == 3'h4 ? eoc_pkg::EOC_RC :
                        m == 3'h5 ? eoc_pkg::EOC_CAP : eoc_pkg::EOC_XTAL;
         exp_drv.div2 = m[0] && m[2:1] != 2'b10;
         exp_drv.use_pin_in = (m[2:1] == 2'b11);
         exp_drv.use_pin_out = 1'b1;
         exp_drv.freq = f;
      end
   endfunction
   task automatic end_of_test();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #40000;
      err_total++;
      end_of_test();
   end
   // Main sequence
   initial
   begin
      void'($urandom(32'h4d48));
      repeat (12) @(negedge sys_clk_i);
      sys_rst_i = 0;
      acc(0, 8'h0F, 8'h9F, 8'h00);
      chk("reset", v, 8'h00);
      chk("rst drv", 8'(drv[9:3]), 8'h00);
      for (int i = 0; i < 40; i++)
      begin
         d = 8'($urandom);
         if (i < 8)
            d[6:4] = 3'(i);
         d[3] = 1'b0;
         acc(1, 8'h0F, 8'h9F, d);
         acc(1, 8'h0F ^ 8'($urandom_range(1, 0)), 8'h9F ^ 8'($urandom_range(1, 1)), ~d);
         acc(0, 8'h0F, 8'h9F, 8'h00);
         chk("reg", v, {1'b0, d[6:4], 1'b0, d[2:0]});
         ex = exp_drv(d[6:4], d[2:0]);
         chk("drive", 8'(drv[9:3]), 8'(ex[9:3]));
         if (ex.osc_enable)
            chk("freq", 8'(drv.freq), 8'(d[2:0]));
         acc(0, 8'h0E, 8'h9F, 8'h00);
         chk("other page", v, 8'h00);
      end
      // Capacitor mode with a mid-range constant
      acc(1, 8'h0F, 8'h9F, 8'h53);
      acc(0, 8'h0F, 8'h9F, 8'h00);
      chk("cap mode", v, 8'h53);
      ex = exp_drv(3'h5, 3'h3);
      chk("cap drive", 8'(drv[9:3]), 8'(ex[9:3]));
      // Crystal mode, top range; poll reads until the valid flag sets
      acc(1, 8'h0F, 8'h9F, 8'h67);
      acc(0, 8'h0F, 8'h9F, 8'h00);
      chk("settling", v, 8'h67);
      for (int n = 0; n < 600 && !v[7]; n++)
         acc(0, 8'h0F, 8'h9F, 8'h00);
      chk("valid", v, 8'hE7);
      // Lowest range keeps the valid flag; CMOS mode then clears it
      acc(1, 8'h0F, 8'h9F, 8'h60);
      acc(0, 8'h0F, 8'h9F, 8'h00);
      chk("low range", v, 8'hE0);
      acc(1, 8'h0F, 8'h9F, 8'h20);
      acc(0, 8'h0F, 8'h9F, 8'h00);
      chk("cmos flag", v, 8'h20);
      // Reset in mid-run clears a running crystal setup
      acc(1, 8'h0F, 8'h9F, 8'h77);
      @(negedge sys_clk_i);
      sys_rst_i = 1;
      repeat (3) @(negedge sys_clk_i);
      sys_rst_i = 0;
      chk("rst2 drv", 8'(drv[9:3]), 8'h00);
      acc(0, 8'h0F, 8'h9F, 8'h00);
      chk("rst2 reg", v, 8'h00);
      end_of_test();
   end
endmodule
